// ---- rtl/dsk_exec.sv ----
// Execution unit for the decrement-register-and-skip instructions
`timescale 1ns/100ps
module dsk_exec
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  start,
  input  wire logic                  skip_on_nonzero,
  input  wire logic                  dest_file,
  input  wire logic                  access_bsr,
  input  wire logic                  ext_enable,
  input  wire logic [7:0]            f_addr,
  input  wire logic [3:0]            bank_selection_register,
  input  wire logic [dsk_pkg::AW-1:0] index_base,
  input  wire logic [1:0]            next_words,
  input  wire logic [dsk_pkg::DW-1:0] file_rdata,
  output logic                       busy,
  output logic [1:0]                 q_phase,
  output logic                       file_rd,
  output logic [dsk_pkg::AW-1:0]     file_addr,
  output logic                       file_wr,
  output logic                       w_wr,
  output logic [dsk_pkg::DW-1:0]     result,
  output logic                       skip_taken,
  output logic                       nop_cycle,
  output logic                       instr_done
);
  dsk_pkg::dsk_state_t state;
  dsk_pkg::dsk_state_t next_state;
  logic                cyc_end;
  logic [1:0]          nop_left;
  logic [1:0]          next_nop_left;
  logic                op_nz;
  logic                next_op_nz;
  logic                op_dest;
  logic                next_op_dest;
  logic [1:0]          op_words;
  logic [1:0]          next_op_words;
  logic [dsk_pkg::AW-1:0] op_addr;
  logic [dsk_pkg::AW-1:0] next_op_addr;
  logic [dsk_pkg::DW-1:0] next_result;
  logic                next_skip_taken;
  logic [dsk_pkg::AW-1:0] eff_addr;
  logic                do_skip;
  logic                accept;

  // Count of one remaining idle cycle, used to end the skip
  localparam logic [1:0] WORDS_ONE_C = dsk_pkg::WORDS_ONE;

  dsk_phase u_phase
  (
    .clk     (clk),
    .rst     (rst),
    .q_phase (q_phase),
    .cyc_end (cyc_end)
  );

  // Effective address from operand, access bit and bank register
  always_comb
  begin
    if (ext_enable && !access_bsr && (f_addr <= dsk_pkg::LIT_OFF_LIMIT))
      eff_addr = index_base + {4'h0, f_addr};
    else if (access_bsr)
      eff_addr = {bank_selection_register, f_addr};
    else if (f_addr < dsk_pkg::ACC_BANK_SPLIT)
      eff_addr = {4'h0, f_addr};
    else
      eff_addr = {dsk_pkg::ACC_HIGH_BANK, f_addr};
  end

  // Start is taken only at a cycle boundary while idle
  assign accept = (state == dsk_pkg::DSK_IDLE) && start && cyc_end;

  // Skip decision from the decremented value
  always_comb
  begin
    do_skip = op_nz ? (result != dsk_pkg::ZERO) : (result == dsk_pkg::ZERO);
  end

  // Sequencer next-state computation
  always_comb
  begin
    next_state      = state;
    next_nop_left   = nop_left;
    next_op_nz      = op_nz;
    next_op_dest    = op_dest;
    next_op_words   = op_words;
    next_op_addr    = op_addr;
    next_result     = result;
    next_skip_taken = skip_taken;
    case (state)
      dsk_pkg::DSK_IDLE:
      begin
        if (accept)
        begin
          next_state      = dsk_pkg::DSK_EXEC;
          next_op_nz      = skip_on_nonzero;
          next_op_dest    = dest_file;
          next_op_words   = (next_words == 2'h0) ? dsk_pkg::WORDS_ONE : next_words;
          next_op_addr    = eff_addr;
          next_skip_taken = 1'b0;
        end
      end
      dsk_pkg::DSK_EXEC:
      begin
        if (q_phase == dsk_pkg::Q_READ)
          next_result = file_rdata - dsk_pkg::ONE;
        if (cyc_end)
        begin
          if (do_skip)
          begin
            next_state      = dsk_pkg::DSK_NOP;
            next_nop_left   = op_words;
            next_skip_taken = 1'b1;
          end
          else
            next_state = dsk_pkg::DSK_IDLE;
        end
      end
      dsk_pkg::DSK_NOP:
      begin
        if (cyc_end)
        begin
          next_nop_left = nop_left - 2'h1;
          if (nop_left == WORDS_ONE_C)
            next_state = dsk_pkg::DSK_IDLE;
        end
      end
      default:
        next_state = dsk_pkg::DSK_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state      <= dsk_pkg::DSK_IDLE;
      nop_left   <= dsk_pkg::NOP_NONE;
      op_nz      <= 1'b0;
      op_dest    <= 1'b1;
      op_words   <= dsk_pkg::WORDS_ONE;
      op_addr    <= '0;
      result     <= dsk_pkg::ZERO;
      skip_taken <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      nop_left   <= next_nop_left;
      op_nz      <= next_op_nz;
      op_dest    <= next_op_dest;
      op_words   <= next_op_words;
      op_addr    <= next_op_addr;
      result     <= next_result;
      skip_taken <= next_skip_taken;
    end
  end

  // Memory strobes and status
  assign busy      = (state != dsk_pkg::DSK_IDLE);
  assign file_addr = op_addr;
  assign file_rd   = (state == dsk_pkg::DSK_EXEC) && (q_phase == dsk_pkg::Q_READ);
  assign file_wr   = (state == dsk_pkg::DSK_EXEC) && (q_phase == dsk_pkg::Q_WRITE) && op_dest;
  assign w_wr      = (state == dsk_pkg::DSK_EXEC) && (q_phase == dsk_pkg::Q_WRITE) && !op_dest;
  assign nop_cycle = (state == dsk_pkg::DSK_NOP);
  assign instr_done = cyc_end &&
    (((state == dsk_pkg::DSK_EXEC) && !do_skip) ||
     ((state == dsk_pkg::DSK_NOP) && (nop_left == WORDS_ONE_C)));

  // Instruction length counter for checking
  logic [2:0] cyc_cnt;
  always_ff @(posedge clk)
  begin
    if (rst || accept)
      cyc_cnt <= 3'h0;
    else if (busy && cyc_end)
      cyc_cnt <= cyc_cnt + 3'h1;
  end

  dec_value_a: assert property (@(posedge clk) disable iff (rst)
    (state == dsk_pkg::DSK_EXEC && q_phase == dsk_pkg::Q_READ) |=>
      result == $past(file_rdata) - dsk_pkg::ONE)
    else $error("result is not read value minus one");

  nz_skip_a: assert property (@(posedge clk) disable iff (rst)
    (state == dsk_pkg::DSK_EXEC && cyc_end && op_nz) |=>
      (nop_cycle == (result != dsk_pkg::ZERO)))
    else $error("nonzero skip decision wrong");

  z_skip_a: assert property (@(posedge clk) disable iff (rst)
    (state == dsk_pkg::DSK_EXEC && cyc_end && !op_nz) |=>
      (nop_cycle == (result == dsk_pkg::ZERO)))
    else $error("zero skip decision wrong");

  // nop cycle has no memory writes
  sequence nop_enter_s;
    state == dsk_pkg::DSK_EXEC && cyc_end && do_skip;
  endsequence
  nop_quiet_a: assert property (@(posedge clk) disable iff (rst)
    nop_enter_s |=> (nop_cycle && !file_wr && !w_wr && !file_rd)[*4])
    else $error("skip cycle not a quiet no-operation");

  dest_sel_a: assert property (@(posedge clk) disable iff (rst)
    (file_wr || w_wr) |-> (file_wr == op_dest) && (w_wr != op_dest))
    else $error("destination select wrong");

  bank_addr_a: assert property (@(posedge clk) disable iff (rst)
    (accept && access_bsr) |=> op_addr == {$past(bank_selection_register), $past(f_addr)})
    else $error("bank register address wrong");

  lit_off_a: assert property (@(posedge clk) disable iff (rst)
    (accept && ext_enable && !access_bsr && f_addr <= dsk_pkg::LIT_OFF_LIMIT) |=>
      op_addr == $past(index_base) + {4'h0, $past(f_addr)})
    else $error("indexed literal offset address wrong");

  length_a: assert property (@(posedge clk) disable iff (rst)
    instr_done |-> (cyc_cnt == (skip_taken ? {1'b0, op_words} : 3'h0)))
    else $error("instruction length wrong");

  // three idle cycles over three words
  sequence exec_s;
    nop_enter_s and (op_words == 2'h3);
  endsequence
  three_nop_a: assert property (@(posedge clk) disable iff (rst)
    exec_s |=> nop_cycle[*8] ##1 nop_cycle[*4] ##1 !nop_cycle)
    else $error("three-word skip not three idle cycles");
endmodule // dsk_exec

// ---- rtl/dsk_pkg.sv ----
// Constants and types for the decrement-and-skip execution block
// Overview of operation
// - Read the addressed file register, subtract one, deliver that as the result.
// - Nonzero-skip form skips when the result is not zero, else continues.
// - A taken skip discards the fetched next word and runs a no-operation cycle.
// - Destination bit 0 writes the working register, 1 writes the file register.
// - Access bit 0 selects the access bank, 1 uses the bank selection register.
// - Extended set, access bit 0, address 95 or less: indexed literal-offset address.
// - One cycle without skip, two with skip, three or four over longer instructions.
// - Skip over a three-word instruction: execute cycle then three all-idle cycles.
// - Zero-skip form skips when the result is zero, else continues.
package dsk_pkg;
  localparam int unsigned DW            = 8;
  localparam int unsigned AW            = 12;
  localparam logic [7:0]  LIT_OFF_LIMIT = 8'h5f;
  localparam logic [7:0]  ACC_BANK_SPLIT = 8'h60;
  localparam logic [3:0]  ACC_HIGH_BANK = 4'hf;
  localparam logic [1:0]  Q_LAST        = 2'h3;
  localparam logic [1:0]  Q_READ        = 2'h1;
  localparam logic [1:0]  Q_WRITE       = 2'h3;
  localparam logic [1:0]  WORDS_ONE     = 2'h1;
  localparam logic [DW-1:0] ONE         = 8'h01;
  localparam logic [DW-1:0] ZERO        = 8'h00;
  localparam logic [1:0]  NOP_NONE      = 2'h0;
  typedef enum logic [1:0]
  {
    DSK_IDLE = 2'b00,
    DSK_EXEC = 2'b01,
    DSK_NOP  = 2'b10
  } dsk_state_t;
endpackage

// ---- rtl/dsk_phase.sv ----
// Four-phase generator dividing the core clock into instruction phases
`timescale 1ns/100ps
module dsk_phase
(
  input  wire logic       clk,
  input  wire logic       rst,
  output logic [1:0]      q_phase,
  output logic            cyc_end
);
  logic [1:0] next_q_phase;

  // Phase counter advances every clock
  always_comb
  begin
    next_q_phase = q_phase + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q_phase <= 2'h0;
    else
      q_phase <= next_q_phase;
  end

  assign cyc_end = (q_phase == dsk_pkg::Q_LAST);
endmodule // dsk_phase

// ---- verif/decrement_skip_execution_test.sv ----
// Self-checking testbench for the decrement-and-skip execution unit
`timescale 1ns/100ps
module decrement_skip_execution_test;
  logic        clk;
  logic        rst;
  logic        start;
  logic        nz_i;
  logic        dst_i;
  logic        acc_i;
  logic        ext_i;
  logic [7:0]  fa_i;
  logic [3:0]  bsr_i;
  logic [11:0] ib_i;
  logic [1:0]  nw_i;
  logic [7:0]  rdata;
  logic        busy;
  logic [1:0]  q_phase;
  logic        file_rd;
  logic [11:0] file_addr;
  logic        file_wr;
  logic        w_wr;
  logic [7:0]  result;
  logic        skip_taken;
  logic        nop_cycle;
  logic        instr_done;
  int          num_errors = 0;
  int          n_compared = 0;

  dsk_exec dut_u (.clk(clk), .rst(rst), .start(start), .skip_on_nonzero(nz_i),
    .dest_file(dst_i), .access_bsr(acc_i), .ext_enable(ext_i), .f_addr(fa_i),
    .bank_selection_register(bsr_i), .index_base(ib_i), .next_words(nw_i),
    .file_rdata(rdata), .busy(busy), .q_phase(q_phase), .file_rd(file_rd),
    .file_addr(file_addr), .file_wr(file_wr), .w_wr(w_wr), .result(result),
    .skip_taken(skip_taken), .nop_cycle(nop_cycle), .instr_done(instr_done));

  // Free-running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare tasks, one per kind of result
  task automatic check_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_vec(name, {15'h0000, exp}, {15'h0000, got});
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One instruction: drive at accept, watch every clock, judge at completion
  task automatic run_instr(input logic nz, input logic dst, input logic acc, input logic ext,
    input logic [7:0] fa, input logic [3:0] bs, input logic [11:0] ib, input logic [1:0] nw,
    input logic [7:0] rd);
    logic [7:0]  res;
    logic [11:0] ea;
    logic        skp;
    int          n, k, nops, rds, fw, ww, bz;
    res = rd - 8'h01;
    skp = nz ? (res != 8'h00) : (res == 8'h00);
    n = skp ? ((nw == 2'h0) ? 1 : int'(nw)) : 0;
    if (acc)
      ea = {bs, fa};
    else if (ext && fa <= 8'h5f)
      ea = ib + {4'h0, fa};
    else
      ea = (fa < 8'h60) ? {4'h0, fa} : {4'hf, fa};
    k = 0;
    while (!(busy === 1'b0 && q_phase === 2'h3) && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    {nz_i, dst_i, acc_i, ext_i, fa_i, bsr_i, ib_i, nw_i, rdata} = {nz, dst, acc, ext, fa, bs,
      ib, nw, rd};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    k = 1;
    {nops, rds, fw, ww, bz} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0};
    check_vec("q_phase_first", 16'h0000, {14'h0000, q_phase});
    while (k < 40)
    begin
      if (file_rd === 1'b1)
      begin
        rds++;
        check_vec("file_addr", {4'h0, ea}, {4'h0, file_addr});
      end
      bz += (busy === 1'b1) ? 1 : 0;
      fw += (file_wr === 1'b1) ? 1 : 0;
      ww += (w_wr === 1'b1) ? 1 : 0;
      nops += (nop_cycle === 1'b1) ? 1 : 0;
      if (instr_done === 1'b1)
        break;
      @(negedge clk);
      k++;
    end
    check_vec("read_count", 16'h0001, 16'(rds));
    check_vec("result", {8'h00, res}, {8'h00, result});
    check_bit("skip_taken", skp, skip_taken);
    check_vec("file_writes", 16'(dst ? 1 : 0), 16'(fw));
    check_vec("w_writes", 16'(dst ? 0 : 1), 16'(ww));
    check_vec("clocks", 16'(4 * (1 + n)), 16'(k));
    check_vec("busy_clocks", 16'(4 * (1 + n)), 16'(bz));
    check_vec("nop_clocks", 16'(4 * n), 16'(nops));
  endtask

  // Nonzero-skip form: skip on 05, continue on 01
  task automatic t_nonzero_form();
    run_instr(1'b1, 1'b1, 1'b1, 1'b0, 8'h12, 4'h3, 12'h000, 2'h1, 8'h05);
    run_instr(1'b1, 1'b0, 1'b1, 1'b0, 8'h34, 4'h5, 12'h000, 2'h1, 8'h01);
  endtask

  // Zero-skip form: skip over two words on 01, wrap to ff without skip
  task automatic t_zero_form();
    run_instr(1'b0, 1'b1, 1'b1, 1'b0, 8'h56, 4'h1, 12'h000, 2'h2, 8'h01);
    run_instr(1'b0, 1'b0, 1'b1, 1'b0, 8'h78, 4'h2, 12'h000, 2'h3, 8'h00);
  endtask

  // Skip lengths over three words and over a zero word count
  task automatic t_long_skip();
    run_instr(1'b1, 1'b1, 1'b1, 1'b0, 8'hff, 4'hf, 12'h000, 2'h3, 8'h80);
    run_instr(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 4'h0, 12'h000, 2'h0, 8'hff);
  endtask

  // Reset in the middle of a long skip returns the sequencer to idle
  task automatic t_mid_reset();
    while (!(busy === 1'b0 && q_phase === 2'h3))
      @(negedge clk);
    {nz_i, acc_i, nw_i, rdata} = {1'b1, 1'b1, 2'h3, 8'h09};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (8) @(negedge clk);
    check_bit("nop_before_reset", 1'b1, nop_cycle);
    rst = 1'b1;
    @(negedge clk);
    check_bit("busy_after_reset", 1'b0, busy);
    check_bit("nop_after_reset", 1'b0, nop_cycle);
    check_vec("q_phase_after_reset", 16'h0000, {14'h0000, q_phase});
    rst = 1'b0;
  endtask

  // Bank and indexed addressing at both sides of the 5f boundary
  task automatic t_addressing();
    run_instr(1'b1, 1'b1, 1'b0, 1'b0, 8'h5f, 4'h7, 12'h300, 2'h1, 8'h01);
    run_instr(1'b1, 1'b1, 1'b0, 1'b0, 8'h60, 4'h7, 12'h300, 2'h1, 8'h01);
    run_instr(1'b1, 1'b1, 1'b0, 1'b1, 8'h5f, 4'h7, 12'h3f0, 2'h1, 8'h01);
    run_instr(1'b1, 1'b1, 1'b0, 1'b1, 8'h60, 4'h7, 12'h3f0, 2'h1, 8'h01);
    run_instr(1'b1, 1'b1, 1'b1, 1'b1, 8'h20, 4'h9, 12'h3f0, 2'h1, 8'h02);
  endtask

  // Main sequence with reset held ten clocks
  initial
  begin
    {rst, start, nz_i, dst_i, acc_i, ext_i} = 6'b100000;
    {fa_i, bsr_i, ib_i, nw_i, rdata} = {8'h00, 4'h0, 12'h000, 2'h1, 8'h00};
    repeat (10) @(negedge clk);
    check_bit("busy_at_reset", 1'b0, busy);
    check_bit("skip_at_reset", 1'b0, skip_taken);
    check_vec("q_phase_at_reset", 16'h0000, {14'h0000, q_phase});
    check_vec("result_at_reset", 16'h0000, {8'h00, result});
    rst = 1'b0;
    t_nonzero_form();
    t_zero_form();
    t_long_skip();
    t_mid_reset();
    t_addressing();
    print_verdict();
  end

  // Watchdog well beyond the expected run of under two hundred clocks
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule // decrement_skip_execution_test
